// ---- common/ack_sched_defs.vh ----
`ifndef ACK_SCHED_DEFS_VH
`define ACK_SCHED_DEFS_VH

// Register byte offsets
`define REG_CTRL        12'h000
`define REG_LINK_CFG    12'h004
`define REG_STANDBY_EXIT 12'h008
`define REG_STATUS      12'h00c
`define REG_SEQ         12'h010
`define REG_COUNT       12'h014
`define REG_THRESH      12'h018

// Control fields
`define CTRL_EARLY_ACK_BIT   0
`define CTRL_STANDBY_EN_BIT  1
`define CTRL_RESET           32'h0000_0000

// Link configuration fields
`define CFG_PAYLOAD_LSB      0
`define CFG_WIDTH_LSB        4
`define CFG_RESET            32'h0000_0000

// Status fields
`define STAT_PENDING_BIT     0
`define STAT_NAK_BIT         1
`define STAT_ACTIVE_BIT      2
`define STAT_WAKE_BIT        3

// Counter and sequence widths and timing
`define COUNT_W              13
`define STANDBY_EXIT_RESET   32'h0000_0000
`define SEQ_W                12

`endif

// ---- src/ack_threshold_lut.v ----
`timescale 1ns/100ps
`default_nettype none
module ack_threshold_lut (
  input  wire [2:0]  payload_code,
  input  wire [2:0]  width_code,
  output reg  [12:0] threshold
);
  always @* begin
    case ({payload_code, width_code})
      6'h00: threshold = 13'h00ed;
      6'h01: threshold = 13'h0080;
      6'h02: threshold = 13'h0049;
      6'h03: threshold = 13'h0043;
      6'h04: threshold = 13'h003a;
      6'h05: threshold = 13'h0030;
      6'h06: threshold = 13'h0021;
      6'h08: threshold = 13'h01a0;
      6'h09: threshold = 13'h00d9;
      6'h0a: threshold = 13'h0076;
      6'h0b: threshold = 13'h006b;
      6'h0c: threshold = 13'h005a;
      6'h0d: threshold = 13'h0048;
      6'h0e: threshold = 13'h002d;
      6'h10: threshold = 13'h022f;
      6'h11: threshold = 13'h0121;
      6'h12: threshold = 13'h009a;
      6'h13: threshold = 13'h0056;
      6'h14: threshold = 13'h006d;
      6'h15: threshold = 13'h0056;
      6'h16: threshold = 13'h0034;
      6'h18: threshold = 13'h042f;
      6'h19: threshold = 13'h0221;
      6'h1a: threshold = 13'h011a;
      6'h1b: threshold = 13'h0096;
      6'h1c: threshold = 13'h00c2;
      6'h1d: threshold = 13'h0096;
      6'h1e: threshold = 13'h0054;
      6'h20: threshold = 13'h082f;
      6'h21: threshold = 13'h0421;
      6'h22: threshold = 13'h021a;
      6'h23: threshold = 13'h0116;
      6'h24: threshold = 13'h016d;
      6'h25: threshold = 13'h0116;
      6'h26: threshold = 13'h0094;
      6'h28: threshold = 13'h102f;
      6'h29: threshold = 13'h0821;
      6'h2a: threshold = 13'h041a;
      6'h2b: threshold = 13'h0216;
      6'h2c: threshold = 13'h02c2;
      6'h2d: threshold = 13'h0216;
      6'h2e: threshold = 13'h0114;
      default: threshold = 13'h102f;
    endcase
  end
endmodule // ack_threshold_lut
`default_nettype wire

// ---- src/apb_regs.v ----
`timescale 1ns/100ps
`default_nettype none
`include "ack_sched_defs.vh"
module apb_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output wire        pready,
  input  wire [31:0] status_in,
  input  wire [31:0] seq_in,
  input  wire [31:0] count_in,
  input  wire [31:0] thresh_in,
  output reg  [31:0] ctrl_ff,
  output reg  [31:0] cfg_ff,
  output reg  [31:0] exit_ff
);
  reg [31:0] rd;
  reg        hit;
  reg        ready_ff;
  // Zero wait states; ready comes from a flop that sets after reset
  assign pready = ready_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= 1'b1;
    end
  end
  always @* begin
    hit = 1'b1;
    case (paddr)
      `REG_CTRL:         rd = ctrl_ff;
      `REG_LINK_CFG:     rd = cfg_ff;
      `REG_STANDBY_EXIT: rd = exit_ff;
      `REG_STATUS:       rd = status_in;
      `REG_SEQ:          rd = seq_in;
      `REG_COUNT:        rd = count_in;
      `REG_THRESH:       rd = thresh_in;
      default: begin
        rd  = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RESET;
      cfg_ff  <= `CFG_RESET;
      exit_ff <= `STANDBY_EXIT_RESET;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      // Error flag is loaded in setup so it stands with the access cycle
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd;
        pslverr <= !hit;
      end
      if (psel && penable) begin
        if (pwrite && paddr == `REG_CTRL) ctrl_ff <= {30'h0, pwdata[1:0]};
        if (pwrite && paddr == `REG_LINK_CFG) cfg_ff <= {25'h0, pwdata[6:4], 1'b0, pwdata[2:0]};
        if (pwrite && paddr == `REG_STANDBY_EXIT) exit_ff <= {20'h0, pwdata[11:0]};
      end
    end
  end
endmodule // apb_regs
`default_nettype wire

// ---- src/ack_latency_scheduler.v ----
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ack_sched_defs.vh"
module ack_latency_scheduler #(
  parameter SEQ_W   = `SEQ_W,
  parameter COUNT_W = `COUNT_W
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire             symbol_tick,
  input  wire             link_layer_active_state,
  input  wire             link_layer_inactive_state,
  input  wire             tlp_forwarded,
  input  wire [SEQ_W-1:0] expected_receive_seq,
  input  wire             nak_scheduled,
  input  wire             nak_sent,
  input  wire             tx_busy,
  input  wire             link_full_on_state,
  input  wire             link_standby_state,
  input  wire [2:0]       min_func_payload,
  input  wire             ack_accept,
  output reg              ack_request,
  output reg  [SEQ_W-1:0] ack_sequence_field,
  output reg              wake_request
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  wire [31:0] ctrl_ff;
  wire [31:0] cfg_ff;
  wire [31:0] exit_ff;
  reg  [COUNT_W-1:0] ack_latency_count_ff;
  reg  [COUNT_W-1:0] nxt_ack_latency_count;
  reg                pending_ff;
  reg                nxt_pending;
  reg                running_ff;
  reg                nxt_running;
  reg  [COUNT_W-1:0] thresh_ff;
  wire [12:0]        table_value;
  wire [2:0]         cfg_payload;
  wire [2:0]         eff_payload;
  wire [COUNT_W:0]   thresh_sum;
  wire               due;
  wire               want_ack;
  wire               issue;

  function [2:0] min3;
    input [2:0] a;
    input [2:0] b;
    begin
      min3 = (a < b) ? a : b;
    end
  endfunction

  assign cfg_payload = cfg_ff[`CFG_PAYLOAD_LSB+2:`CFG_PAYLOAD_LSB];
  assign eff_payload = min3(cfg_payload, min_func_payload);

  //////////////////////////////////////////////////////////////////////////////
  // Threshold selection
  ack_threshold_lut u_lut (
    .payload_code (eff_payload),
    .width_code   (cfg_ff[`CFG_WIDTH_LSB+2:`CFG_WIDTH_LSB]),
    .threshold    (table_value)
  );

  assign thresh_sum = {1'b0, table_value}
                    + (ctrl_ff[`CTRL_STANDBY_EN_BIT] ? {2'b00, exit_ff[11:0]}
                                                     : {(COUNT_W+1){1'b0}});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_ff <= {COUNT_W{1'b1}};
    end else begin
      thresh_ff <= thresh_sum[COUNT_W] ? {COUNT_W{1'b1}} : thresh_sum[COUNT_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ack decision
  assign due      = (ack_latency_count_ff >= thresh_ff) && !nak_scheduled;
  assign want_ack = link_layer_active_state && pending_ff
                    && (due || ctrl_ff[`CTRL_EARLY_ACK_BIT]);
  assign issue    = ack_request && ack_accept;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_request        <= 1'b0;
      ack_sequence_field <= {SEQ_W{1'b0}};
      wake_request       <= 1'b0;
    end else begin
      ack_request        <= want_ack && link_full_on_state && !tx_busy && !issue;
      ack_sequence_field <= expected_receive_seq - {{(SEQ_W-1){1'b0}}, 1'b1};
      wake_request       <= want_ack
                            && (!link_full_on_state || link_standby_state);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outstanding tracking and counter
  always @* begin
    nxt_pending           = pending_ff;
    nxt_running           = running_ff;
    nxt_ack_latency_count = ack_latency_count_ff;
    if (tlp_forwarded) begin
      nxt_pending = 1'b1;
      nxt_running = 1'b1;
    end
    if (running_ff && symbol_tick && ack_latency_count_ff != {COUNT_W{1'b1}}) begin
      nxt_ack_latency_count = ack_latency_count_ff + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
    if (issue || nak_sent) begin
      nxt_ack_latency_count = {COUNT_W{1'b0}};
    end
    if (issue && !tlp_forwarded) begin
      nxt_pending           = 1'b0;
      nxt_running           = 1'b0;
      nxt_ack_latency_count = {COUNT_W{1'b0}};
    end
    if (link_layer_inactive_state) begin
      nxt_pending           = 1'b0;
      nxt_running           = 1'b0;
      nxt_ack_latency_count = {COUNT_W{1'b0}};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_ff           <= 1'b0;
      running_ff           <= 1'b0;
      ack_latency_count_ff <= {COUNT_W{1'b0}};
    end else begin
      pending_ff           <= nxt_pending;
      running_ff           <= nxt_running;
      ack_latency_count_ff <= nxt_ack_latency_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bus
  apb_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .pready    (pready),
    .status_in ({28'h0, wake_request, link_layer_active_state, nak_scheduled, pending_ff}),
    .seq_in    ({{(32-SEQ_W){1'b0}}, ack_sequence_field}),
    .count_in  ({{(32-COUNT_W){1'b0}}, ack_latency_count_ff}),
    .thresh_in ({{(32-COUNT_W){1'b0}}, thresh_ff}),
    .ctrl_ff   (ctrl_ff),
    .cfg_ff    (cfg_ff),
    .exit_ff   (exit_ff)
  );
endmodule // ack_latency_scheduler
`default_nettype wire

// ---- test/ack_sched_checker_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module ack_sched_checker #(parameter SEQ_W = 12) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             link_layer_active_state,
  input wire logic             link_full_on_state,
  input wire logic             tx_busy,
  input wire logic             ack_accept,
  input wire logic             ack_request,
  input wire logic [SEQ_W-1:0] expected_receive_seq,
  input wire logic [SEQ_W-1:0] ack_sequence_field
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ack_waiting; ack_request && !ack_accept && link_layer_active_state; endsequence
  sequence ack_taken; ack_request && ack_accept; endsequence
  seq_field_a:
    assert property ($past(presetn) |-> ack_sequence_field ==
      SEQ_W'($past(expected_receive_seq) - 1)) else $error("ack sequence field off");
  ack_hold_a:
    assert property (ack_waiting |=> ack_request) else $error("ack request dropped");
  ack_drop_a:
    assert property (ack_taken |=> !ack_request) else $error("ack request stuck");
  idle_quiet_a:
    assert property (!link_layer_active_state && !ack_request |=> !ack_request)
      else $error("ack while link idle");
  busy_wait_a:
    assert property (tx_busy && !ack_request |=> !ack_request) else $error("ack while busy");
  full_on_a:
    assert property ($rose(ack_request) |-> $past(link_full_on_state))
      else $error("ack outside full-on");
  pready_one_a:
    assert property (psel |-> pready) else $error("pready low");
  slverr_when_a:
    assert property ($rose(pslverr) |-> $past(psel && !penable)) else $error("stray slverr");
endmodule // ack_sched_checker
bind ack_latency_scheduler ack_sched_checker #(.SEQ_W(SEQ_W)) ack_sched_checker_inst (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .link_layer_active_state,
  .link_full_on_state, .tx_busy, .ack_accept, .ack_request, .expected_receive_seq,
  .ack_sequence_field);
`default_nettype wire

// ---- test/link_tx_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module link_tx_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ack_request,
  input wire logic [3:0] delay,
  output logic           ack_accept
);
  logic [3:0] wait_ff;
  // Takes the Ack after a chosen number of cycles
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wait_ff <= 4'h0;
    else if (!ack_request || ack_accept) wait_ff <= 4'h0;
    else wait_ff <= wait_ff + 4'h1;
  assign ack_accept = ack_request && wait_ff >= delay;
endmodule // link_tx_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ack_sched_defs.vh"
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        tick = 1, act = 0, inact = 1, tlp = 0, nak = 0, busy = 0, full_on = 1;
  logic        nak_tx = 0, half = 0;
  logic [11:0] paddr = 0, seq = 0, s;
  logic [31:0] pwdata = 0;
  logic [2:0]  min_pl = 3'h7;
  logic [3:0]  delay = 0;
  wire  [31:0] prdata;
  wire  [11:0] ack_sequence_field;
  wire         pready, pslverr, ack_request, ack_accept, wake_request;
  int          n_fail = 0, check_count = 0, n;
  logic [31:0] rq[$], aq[$];
  int cf[5] = '{'h00, 'h65, 'h32, 'h65, 'h41};
  int mp[5] = '{7, 7, 7, 0, 7};
  int th[5] = '{237, 276, 86, 33, 90};
  always #5 pclk = ~pclk;
  // Symbol time every cycle, or every other cycle when half is set
  always @(posedge pclk) tick <= half ? ~tick : 1'b1;
  ack_latency_scheduler ack_latency_scheduler_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .symbol_tick(tick),
    .link_layer_active_state(act), .link_layer_inactive_state(inact), .tlp_forwarded(tlp),
    .expected_receive_seq(seq), .nak_scheduled(nak), .nak_sent(nak_tx), .tx_busy(busy),
    .link_full_on_state(full_on), .link_standby_state(!full_on), .min_func_payload(min_pl),
    .ack_accept, .ack_request, .ack_sequence_field, .wake_request);
  link_tx_model link_tx_model_inst (.pclk, .presetn, .ack_request, .delay, .ack_accept);
  //////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 50);
    if (k >= 50) begin
      n_fail++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse;
    s = 12'($urandom);
    seq <= s;
    aq.push_back({20'h0, s - 12'h1});
    @(posedge pclk);
    tlp <= 1'b1;
    @(posedge pclk);
    tlp <= 1'b0;
  endtask
  task automatic wait_ack;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!ack_request && n < 400);
    if (n >= 400) begin
      n_fail++;
      wrap_up();
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check(prdata, rq.pop_front());
    if (psel && penable && pready) check(pslverr, {31'h0, paddr > `REG_THRESH});
    if (ack_request && ack_accept) check(ack_sequence_field, aq.pop_front());
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(17);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_CTRL, 32'h0);
    rd(12'h01c, 32'h0);
    for (int i = 0; i < 5; i++) begin
      min_pl <= mp[i];
      apb(1'b1, `REG_LINK_CFG, cf[i]);
      rd(`REG_THRESH, th[i]);
    end
    apb(1'b1, `REG_CTRL, 32'h2);
    apb(1'b1, `REG_STANDBY_EXIT, 32'ha);
    rd(`REG_THRESH, 32'd100);
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_LINK_CFG, 32'h60);
    $display("threshold table done");
    act <= 1'b1;
    inact <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      delay <= 4'(k * 3);
      half <= (k == 3);
      pulse();
      if (k == 2) begin
        repeat (20) @(posedge pclk);
        nak_tx <= 1'b1;
        @(posedge pclk);
        nak_tx <= 1'b0;
      end
      wait_ack();
      check(n >= 33 * (1 + half) && n <= 40 * (1 + half), 1);
      repeat (10) @(posedge pclk);
      rd(`REG_COUNT, 32'h0);
    end
    half <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      busy <= (i == 0);
      nak <= (i == 1);
      full_on <= (i != 2);
      pulse();
      repeat (50) @(posedge pclk);
      check({wake_request, ack_request}, {i == 2, 1'b0});
      busy <= 1'b0;
      nak <= 1'b0;
      full_on <= 1'b1;
      wait_ack();
      check(n <= 4, 1);
      repeat (10) @(posedge pclk);
    end
    apb(1'b1, `REG_CTRL, 32'h1);
    pulse();
    wait_ack();
    check(n <= 8, 1);
    repeat (10) @(posedge pclk);
    $display("ack scheduling done");
    act <= 1'b0;
    inact <= 1'b1;
    @(posedge pclk);
    tlp <= 1'b1;
    @(posedge pclk);
    tlp <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(`REG_COUNT, 32'h0);
    check(ack_request, 0);
    $display("inactive link done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
